/* File: design/lcc_pkg.sv */
// Package: register map, field layout and encodings of the logic cell control block
package lcc_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_POL = 8'h04;
   localparam logic [7:0] OFS_SEL_A = 8'h08;
   localparam logic [7:0] OFS_SEL_B = 8'h0C;
   localparam logic [7:0] OFS_SEL_C = 8'h10;
   localparam logic [7:0] OFS_SEL_D = 8'h14;
   localparam logic [7:0] OFS_GLS_A = 8'h18;
   localparam logic [7:0] OFS_GLS_B = 8'h1C;
   localparam logic [7:0] OFS_GLS_C = 8'h20;
   localparam logic [7:0] OFS_GLS_D = 8'h24;
   localparam logic [7:0] OFS_FLAG = 8'h28;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_OUT_BIT = 5;
   localparam int CTRL_RISE_BIT = 4;
   localparam int CTRL_FALL_BIT = 3;
   localparam int CTRL_MODE_LSB = 0;
   localparam int POL_OUT_BIT = 7;
   localparam int POL_GATE_LSB = 0;
   localparam int FLAG_BIT = 0;
   localparam int MODE_W = 3;
   localparam int SEL_W = 6;
   localparam int GLS_W = 8;
   localparam int NUM_INPUTS = 4;
   // ------------------------------------------------------------
   // Reset values and source table
   // ------------------------------------------------------------
   localparam logic CTRL_RST = 1'b0;
   localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
   localparam logic POL_OUT_RST = 1'b0;
   localparam int NUM_SRC = 40;
   localparam logic [SEL_W-1:0] SRC_FAST_OSC = 6'h05;
   // ------------------------------------------------------------
   // Function encodings
   // ------------------------------------------------------------
   localparam logic [MODE_W-1:0] MODE_AND_OR = 3'h0;
   localparam logic [MODE_W-1:0] MODE_OR_XOR = 3'h1;
   localparam logic [MODE_W-1:0] MODE_AND4 = 3'h2;
   localparam logic [MODE_W-1:0] MODE_SR_LATCH = 3'h3;
   localparam logic [MODE_W-1:0] MODE_DFF_SR = 3'h4;
   localparam logic [MODE_W-1:0] MODE_DFF2_R = 3'h5;
   localparam logic [MODE_W-1:0] MODE_JK_R = 3'h6;
   localparam logic [MODE_W-1:0] MODE_LATCH_SR = 3'h7;
endpackage

/* File: design/lcc_func.sv */
// Logic function stage of the cell: combinational and self-timed sequential functions
`timescale 1ns/1ps
module lcc_func (
   input wire logic [3:0] gate,
   input wire logic [lcc_pkg::MODE_W-1:0] mode,
   input wire logic clear,
   output logic func_out
);
   // ------------------------------------------------------------
   // Gate roles for the stateful functions
   // ------------------------------------------------------------
   // Flip-flops are clocked by gate a and latches run on the gates, not pclk, so storage keeps working while the core sleeps
   logic ff_set;
   logic ff_rst;
   logic latch_rst;
   logic q_dff;
   logic q_dff2;
   logic q_jk;
   logic q_sr;
   logic q_lat;
   logic s_in;
   logic r_in;
   assign ff_rst = gate[2] | clear;
   assign ff_set = gate[3] & ~clear;
   assign latch_rst = gate[0] | clear;
   assign s_in = gate[0] | gate[1];
   assign r_in = gate[2] | gate[3];

   always_ff @(posedge gate[0] or posedge ff_rst or posedge ff_set) begin
      if (ff_rst) begin
         q_dff <= 1'b0;
      end else if (ff_set) begin
         q_dff <= 1'b1;
      end else begin
         q_dff <= gate[1];
      end
   end

   always_ff @(posedge gate[0] or posedge ff_rst) begin
      if (ff_rst) begin
         q_dff2 <= 1'b0;
      end else begin
         q_dff2 <= gate[1] & gate[3];
      end
   end

   always_ff @(posedge gate[0] or posedge ff_rst) begin
      if (ff_rst) begin
         q_jk <= 1'b0;
      end else begin
         case ({gate[1], gate[3]})
            2'b10: q_jk <= 1'b1;
            2'b01: q_jk <= 1'b0;
            2'b11: q_jk <= ~q_jk;
            default: q_jk <= q_jk;
         endcase
      end
   end

   // Set dominates reset in the S-R latch
   always_latch begin
      if (clear) begin
         q_sr = 1'b0;
      end else if (s_in) begin
         q_sr = 1'b1;
      end else if (r_in) begin
         q_sr = 1'b0;
      end
   end

   // Transparent while gate c is low
   always_latch begin
      if (latch_rst) begin
         q_lat = 1'b0;
      end else if (gate[3]) begin
         q_lat = 1'b1;
      end else if (!gate[2]) begin
         q_lat = gate[1];
      end
   end

   // ------------------------------------------------------------
   // Function select
   // ------------------------------------------------------------
   always_comb begin
      case (mode)
         lcc_pkg::MODE_AND_OR: func_out = (gate[0] & gate[1]) | (gate[2] & gate[3]);
         lcc_pkg::MODE_OR_XOR: func_out = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
         lcc_pkg::MODE_AND4: func_out = &gate;
         lcc_pkg::MODE_SR_LATCH: func_out = q_sr;
         lcc_pkg::MODE_DFF_SR: func_out = q_dff;
         lcc_pkg::MODE_DFF2_R: func_out = q_dff2;
         lcc_pkg::MODE_JK_R: func_out = q_jk;
         lcc_pkg::MODE_LATCH_SR: func_out = q_lat;
         default: func_out = 1'b0;
      endcase
   end
endmodule // lcc_func

/* File: design/lcc_cell.sv */
// Configurable logic cell: APB registers, input routing, gating, output and edge flag
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Cell logic runs without pclk, survives sleep
// - Fast oscillator kept awake when enabled, selected
// - Enable bit 7; disabled cell outputs zero
// - Bit 5 reads synchronized final output copy
// - Rising-edge enable lets rising edges set flag
// - Falling-edge enable lets falling edges set flag
// - Three-bit field picks one of eight functions
// - Polarity bit 7 inverts final output
// - Polarity bits 0-3 invert gate outputs
// - Four six-bit select fields route data inputs
// - Unimplemented bits ignore writes, read zero
// - Control, output polarity and flag reset; others kept
// - Codes 0-39 pick sources, higher read zero
// - Gate with nothing enabled gives polarity constant
// - Gate enables: true/negated pair per input
// - Output polarity change counts as an edge
module lcc_cell #(
   parameter int NUM_SRC = lcc_pkg::NUM_SRC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NUM_SRC-1:0] src_in,
   output logic cell_output_signal,
   output logic cell_irq_flag,
   output logic fast_osc_keep_awake
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic sel_src(input logic [NUM_SRC-1:0] src,
                                    input logic [lcc_pkg::SEL_W-1:0] code);
      sel_src = (int'(code) < NUM_SRC) ? src[code] : 1'b0;
   endfunction

   // Odd bit gates the true input, even bit the negated one
   function automatic logic gate_or(input logic [lcc_pkg::GLS_W-1:0] en,
                                    input logic [3:0] d);
      logic acc;
      acc = 1'b0;
      for (int j = 0; j < lcc_pkg::NUM_INPUTS; j++) begin
         acc = acc | (en[2*j+1] & d[j]) | (en[2*j] & ~d[j]);
      end
      gate_or = acc;
   endfunction

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic cell_enable_bit;
   logic rise_irq_enable;
   logic fall_irq_enable;
   logic [lcc_pkg::MODE_W-1:0] cell_function_select;
   logic output_invert;
   logic [3:0] gate_inv_r;
   logic [lcc_pkg::SEL_W-1:0] sel_r [lcc_pkg::NUM_INPUTS];
   logic [lcc_pkg::GLS_W-1:0] gls_r [lcc_pkg::NUM_INPUTS];
   logic flag_r;
   logic flag_nxt;
   logic out_s1_r;
   logic out_s2_r;
   logic out_d_r;
   logic [31:0] prdata_r;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire wr_en = psel & penable & pwrite;
   wire rd_setup = psel & ~penable & ~pwrite;
   wire hit_ctrl = (paddr == lcc_pkg::OFS_CTRL);
   wire hit_pol = (paddr == lcc_pkg::OFS_POL);
   wire hit_sel_a = (paddr == lcc_pkg::OFS_SEL_A);
   wire hit_sel_b = (paddr == lcc_pkg::OFS_SEL_B);
   wire hit_sel_c = (paddr == lcc_pkg::OFS_SEL_C);
   wire hit_sel_d = (paddr == lcc_pkg::OFS_SEL_D);
   wire hit_gls_a = (paddr == lcc_pkg::OFS_GLS_A);
   wire hit_gls_b = (paddr == lcc_pkg::OFS_GLS_B);
   wire hit_gls_c = (paddr == lcc_pkg::OFS_GLS_C);
   wire hit_gls_d = (paddr == lcc_pkg::OFS_GLS_D);
   wire hit_flag = (paddr == lcc_pkg::OFS_FLAG);
   wire [3:0] hit_sel = {hit_sel_d, hit_sel_c, hit_sel_b, hit_sel_a};
   wire [3:0] hit_gls = {hit_gls_d, hit_gls_c, hit_gls_b, hit_gls_a};
   wire mapped = hit_ctrl | hit_pol | (|hit_sel) | (|hit_gls) | hit_flag;

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // ------------------------------------------------------------
   // Datapath: routing, gating, function, output polarity
   // ------------------------------------------------------------
   logic [3:0] data_in;
   logic [3:0] gate_raw;
   logic [3:0] gate_val;
   logic func_out;

   // Routing settles first, so every gate sees this pass's inputs
   always_comb begin
      for (int i = 0; i < lcc_pkg::NUM_INPUTS; i++) begin
         data_in[i] = sel_src(src_in, sel_r[i]);
      end
      for (int i = 0; i < lcc_pkg::NUM_INPUTS; i++) begin
         gate_raw[i] = gate_or(gls_r[i], data_in);
         gate_val[i] = gate_raw[i] ^ gate_inv_r[i];
      end
   end

   // Unclocked path: the cell keeps producing output with pclk stopped
   lcc_func u_func (
      .gate(gate_val),
      .mode(cell_function_select),
      .clear(~cell_enable_bit | ~presetn),
      .func_out(func_out)
   );

   assign cell_output_signal = cell_enable_bit & (func_out ^ output_invert);

   wire [3:0] fast_sel;
   for (genvar k = 0; k < lcc_pkg::NUM_INPUTS; k++) begin : g_fast
      assign fast_sel[k] = (sel_r[k] == lcc_pkg::SRC_FAST_OSC);
   end
   assign fast_osc_keep_awake = cell_enable_bit & (|fast_sel);

   // ------------------------------------------------------------
   // Control and output polarity (cleared by every reset)
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cell_enable_bit <= lcc_pkg::CTRL_RST;
         rise_irq_enable <= lcc_pkg::CTRL_RST;
         fall_irq_enable <= lcc_pkg::CTRL_RST;
         cell_function_select <= lcc_pkg::MODE_RST;
         output_invert <= lcc_pkg::POL_OUT_RST;
      end else begin
         if (wr_en && hit_ctrl) begin
            cell_enable_bit <= pwdata[lcc_pkg::CTRL_EN_BIT];
            rise_irq_enable <= pwdata[lcc_pkg::CTRL_RISE_BIT];
            fall_irq_enable <= pwdata[lcc_pkg::CTRL_FALL_BIT];
            cell_function_select <= pwdata[lcc_pkg::CTRL_MODE_LSB +: lcc_pkg::MODE_W];
         end
         if (wr_en && hit_pol) begin
            output_invert <= pwdata[lcc_pkg::POL_OUT_BIT];
         end
      end
   end

   // Selection and gating keep their values across resets; unknown at power-up
   always_ff @(posedge pclk) begin
      if (wr_en && hit_pol) begin
         gate_inv_r <= pwdata[lcc_pkg::POL_GATE_LSB +: 4];
      end
      for (int i = 0; i < lcc_pkg::NUM_INPUTS; i++) begin
         if (wr_en && hit_sel[i]) begin
            sel_r[i] <= pwdata[lcc_pkg::SEL_W-1:0];
         end
         if (wr_en && hit_gls[i]) begin
            gls_r[i] <= pwdata[lcc_pkg::GLS_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Output sampling and edge flag
   // ------------------------------------------------------------
   wire rise_ev = out_s2_r & ~out_d_r;
   wire fall_ev = ~out_s2_r & out_d_r;
   wire flag_set = (rise_ev & rise_irq_enable) | (fall_ev & fall_irq_enable);
   wire flag_clr = wr_en & hit_flag & pwdata[lcc_pkg::FLAG_BIT];

   // A set in the cycle of a clear wins, so no edge is lost
   assign flag_nxt = flag_set | (flag_r & ~flag_clr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_s1_r <= 1'b0;
         out_s2_r <= 1'b0;
         out_d_r <= 1'b0;
         flag_r <= 1'b0;
      end else begin
         out_s1_r <= cell_output_signal;
         out_s2_r <= out_s1_r;
         out_d_r <= out_s2_r;
         flag_r <= flag_nxt;
      end
   end
   assign cell_irq_flag = flag_r;

   // ------------------------------------------------------------
   // Read data, captured in the setup phase
   // ------------------------------------------------------------
   wire [7:0] ctrl_rd = {cell_enable_bit, 1'b0, out_s2_r, rise_irq_enable,
                         fall_irq_enable, cell_function_select};
   wire [7:0] pol_rd = {output_invert, 3'h0, gate_inv_r};
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      if (hit_ctrl) rd_byte = ctrl_rd;
      if (hit_pol) rd_byte = pol_rd;
      if (hit_flag) rd_byte = {7'h00, flag_r};
      for (int i = 0; i < lcc_pkg::NUM_INPUTS; i++) begin
         if (hit_sel[i]) rd_byte = {2'h0, sel_r[i]};
         if (hit_gls[i]) rd_byte = gls_r[i];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_r <= {24'h00_0000, rd_byte};
      end
   end
   assign prdata = prdata_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_rise_seen;
      rise_ev && rise_irq_enable;
   endsequence
   sequence s_fall_seen;
      fall_ev && fall_irq_enable;
   endsequence

   property p_off_zero;
      @(posedge pclk) disable iff (!presetn) !cell_enable_bit |-> !cell_output_signal;
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("disabled cell drives one");

   property p_copy;
      @(posedge pclk) disable iff (!presetn)
         (cell_output_signal == 1'b1) [*3] |-> ctrl_rd[lcc_pkg::CTRL_OUT_BIT];
   endproperty
   a_copy: assert property (p_copy) else $error("output copy lags past two cycles");

   property p_rise;
      @(posedge pclk) disable iff (!presetn) s_rise_seen |=> cell_irq_flag;
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge did not set flag");

   property p_fall;
      @(posedge pclk) disable iff (!presetn) s_fall_seen |=> cell_irq_flag;
   endproperty
   a_fall: assert property (p_fall) else $error("falling edge did not set flag");

   property p_no_spurious;
      @(posedge pclk) disable iff (!presetn)
         !cell_irq_flag && !(rise_ev && rise_irq_enable) && !(fall_ev && fall_irq_enable)
         |=> !cell_irq_flag;
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("flag set without edge");

   property p_out_pol;
      @(posedge pclk) disable iff (!presetn)
         cell_enable_bit |-> cell_output_signal == (func_out ^ output_invert);
   endproperty
   a_out_pol: assert property (p_out_pol) else $error("output polarity wrong");

   property p_pol_rd;
      @(posedge pclk) disable iff (!presetn) rd_setup && hit_pol |=> prdata[6:4] == 3'h0;
   endproperty
   a_pol_rd: assert property (p_pol_rd) else $error("unimplemented bits read nonzero");

   property p_reset_ctrl;
      @(posedge pclk) $rose(presetn) |-> ctrl_rd == 8'h00 && !output_invert;
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not cleared by reset");

   property p_keep_awake;
      @(posedge pclk) disable iff (!presetn)
         cell_enable_bit && sel_r[0] == lcc_pkg::SRC_FAST_OSC |-> fast_osc_keep_awake;
   endproperty
   a_keep_awake: assert property (p_keep_awake) else $error("oscillator not held");

   property p_set_wins;
      @(posedge pclk) disable iff (!presetn) flag_set && flag_clr |=> cell_irq_flag;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a new edge");

   property p_flag_hold;
      @(posedge pclk) disable iff (!presetn) cell_irq_flag && !flag_clr |=> cell_irq_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a clear");

   property p_copy_low;
      @(posedge pclk) disable iff (!presetn)
         (cell_output_signal == 1'b0) [*3] |-> !ctrl_rd[lcc_pkg::CTRL_OUT_BIT];
   endproperty
   a_copy_low: assert property (p_copy_low) else $error("low output copy lags");

   property p_reserved_low;
      @(posedge pclk) disable iff (!presetn) int'(sel_r[3]) >= NUM_SRC |-> !data_in[3];
   endproperty
   a_reserved_low: assert property (p_reserved_low) else $error("reserved source seen");

endmodule // lcc_cell

/* File: test/configurable_logic_cell_control_test.sv */
// Testbench: register access, cell functions, gating, polarity and edge flag checks
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module configurable_logic_cell_control_test;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [lcc_pkg::NUM_SRC-1:0] src_in = '0;
   logic cell_output_signal;
   logic cell_irq_flag;
   logic fast_osc_keep_awake;
   int err_count = 0;
   int total_checks = 0;
   logic [31:0] rd_q;
   logic rd_err;
   logic [5:0] sel_map [4];
   logic [2:0] prev_m;
   logic [7:0] sel_ofs [4] = '{lcc_pkg::OFS_SEL_A, lcc_pkg::OFS_SEL_B, lcc_pkg::OFS_SEL_C,
      lcc_pkg::OFS_SEL_D};
   logic [7:0] gls_ofs [4] = '{lcc_pkg::OFS_GLS_A, lcc_pkg::OFS_GLS_B, lcc_pkg::OFS_GLS_C,
      lcc_pkg::OFS_GLS_D};
   // Entry: mode, gate inputs g3..g0, expected output
   // Reset release and set never share a step: event order would decide the result
   logic [7:0] seq_tab [28] = '{8'h63, 8'h61, 8'h68, 8'h60, 8'h84, 8'h87, 8'h81, 8'h88, 8'h80,
      8'h91, 8'hA4, 8'hA6, 8'hB4, 8'hB7, 8'hA8, 8'hC4, 8'hC7, 8'hD1, 8'hD2, 8'hD4, 8'hD7,
      8'hC8, 8'hE5, 8'hED, 8'hE9, 8'hE0, 8'hF9, 8'hEA};

   lcc_cell #(.NUM_SRC(lcc_pkg::NUM_SRC)) dut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .src_in(src_in),
      .cell_output_signal(cell_output_signal),
      .cell_irq_flag(cell_irq_flag),
      .fast_osc_keep_awake(fast_osc_keep_awake)
   );

   always #20 pclk = ~pclk;

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_q = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Returns past the write edge, so its effect is settled when looked at
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb_xfer(1'b1, a, d);
      @(negedge pclk);
   endtask
   task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb_xfer(1'b0, a, 8'h00);
      `CHK(nm, exp, rd_q)
   endtask
   // Routes gate inputs to the selected sources; reserved codes are left low
   function automatic logic [lcc_pkg::NUM_SRC-1:0] route(input logic [3:0] v);
      logic [lcc_pkg::NUM_SRC-1:0] s;
      s = '0;
      for (int j = 0; j < 4; j++) begin
         if (sel_map[j] < 6'h28) begin
            s[sel_map[j]] = v[j];
         end
      end
      return s;
   endfunction
   task automatic apply(input logic [3:0] v);
      @(posedge pclk);
      src_in <= route(v);
      @(negedge pclk);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   // Cell is disabled while the mode changes, so sequential storage starts cleared
   task automatic cfg_mode(input logic [2:0] m);
      wr(lcc_pkg::OFS_CTRL, {5'h00, m});
      apply(4'h0);
      wr(lcc_pkg::OFS_CTRL, {5'h10, m});
   endtask
   function automatic logic comb_fn(input logic [2:0] m, input logic [3:0] g);
      case (m)
         lcc_pkg::MODE_AND_OR: return (g[0] & g[1]) | (g[2] & g[3]);
         lcc_pkg::MODE_OR_XOR: return (g[0] | g[1]) ^ (g[2] | g[3]);
         default: return &g;
      endcase
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      give_verdict();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk_rd("control after reset", lcc_pkg::OFS_CTRL, 32'h00000000);
      apb_xfer(1'b0, lcc_pkg::OFS_POL, 8'h00);
      `CHK("output invert after reset", 1'b0, rd_q[7])
      wr(lcc_pkg::OFS_CTRL, 8'h7F);
      chk_rd("control fields", lcc_pkg::OFS_CTRL, 32'h0000001F);
      `CHK("disabled output", 1'b0, cell_output_signal)
      for (int j = 0; j < 4; j++) begin
         wr(sel_ofs[j], 8'hFF);
         chk_rd("select field", sel_ofs[j], 32'h0000003F);
      end
      wr(lcc_pkg::OFS_POL, 8'hFF);
      chk_rd("polarity fields", lcc_pkg::OFS_POL, 32'h0000008F);
      chk_rd("unmapped read", 8'h2C, 32'h00000000);
      `CHK("unmapped error", 1'b1, rd_err)
      $display("test registers done");
      // Identity routing: gate j passes data j true
      for (int j = 0; j < 4; j++) begin
         wr(sel_ofs[j], 8'(j));
         sel_map[j] = 6'(j);
         wr(gls_ofs[j], 8'h02 << (2 * j));
      end
      wr(lcc_pkg::OFS_POL, 8'h00);
      for (int m = 0; m < 3; m++) begin
         cfg_mode(3'(m));
         for (int v = 0; v < 16; v++) begin
            apply(4'(v));
            `CHK("combinational output", comb_fn(3'(m), 4'(v)), cell_output_signal)
         end
      end
      prev_m = 3'h0;
      for (int i = 0; i < 28; i++) begin
         if (seq_tab[i][7:5] !== prev_m) begin
            cfg_mode(seq_tab[i][7:5]);
            prev_m = seq_tab[i][7:5];
         end
         apply(seq_tab[i][4:1]);
         `CHK("sequential output", seq_tab[i][0], cell_output_signal)
      end
      $display("test functions done");
      // Gate a empty, b negated, c true with inverted gate, d true
      wr(lcc_pkg::OFS_CTRL, 8'h02);
      sel_map = '{6'h27, 6'h05, 6'h11, 6'h03};
      for (int j = 0; j < 4; j++) begin
         wr(sel_ofs[j], {2'h0, sel_map[j]});
      end
      wr(gls_ofs[0], 8'h00);
      wr(gls_ofs[1], 8'h04);
      for (int p = 0; p < 2; p++) begin
         wr(lcc_pkg::OFS_CTRL, 8'h02);
         wr(lcc_pkg::OFS_POL, p ? 8'h85 : 8'h05);
         wr(lcc_pkg::OFS_CTRL, 8'h82);
         `CHK("keep awake", 1'b1, fast_osc_keep_awake)
         for (int v = 0; v < 16; v++) begin
            apply(4'(v));
            `CHK("gated output", 1'(~v[1] & ~v[2] & v[3] ^ p), cell_output_signal)
         end
      end
      // Reserved code on data d reads low; its negated term then holds the gate high
      wr(lcc_pkg::OFS_CTRL, 8'h02);
      `CHK("keep awake disabled", 1'b0, fast_osc_keep_awake)
      wr(sel_ofs[3], 8'h2D);
      wr(gls_ofs[3], 8'h40);
      wr(gls_ofs[1], 8'h00);
      wr(lcc_pkg::OFS_POL, 8'h03);
      wr(lcc_pkg::OFS_CTRL, 8'h82);
      @(posedge pclk);
      src_in <= '1;
      @(negedge pclk);
      `CHK("reserved source", 1'b1, cell_output_signal)
      $display("test gating done");
      // Output follows data a on source 39
      wr(lcc_pkg::OFS_CTRL, 8'h02);
      wr(gls_ofs[0], 8'h02);
      wr(gls_ofs[3], 8'h00);
      wr(lcc_pkg::OFS_POL, 8'h0E);
      sel_map[3] = 6'h2D;
      apply(4'h0);
      wr(lcc_pkg::OFS_CTRL, 8'h92);
      wr(lcc_pkg::OFS_FLAG, 8'h01);
      wait_cyc(6);
      `CHK("flag cleared", 1'b0, cell_irq_flag)
      apply(4'h1);
      wait_cyc(6);
      `CHK("rise flag", 1'b1, cell_irq_flag)
      chk_rd("output copy high", lcc_pkg::OFS_CTRL, 32'h000000B2);
      wr(lcc_pkg::OFS_FLAG, 8'h01);
      wait_cyc(6);
      `CHK("flag once", 1'b0, cell_irq_flag)
      apply(4'h0);
      wait_cyc(6);
      `CHK("fall without enable", 1'b0, cell_irq_flag)
      chk_rd("output copy low", lcc_pkg::OFS_CTRL, 32'h00000092);
      wr(lcc_pkg::OFS_CTRL, 8'h8A);
      apply(4'h1);
      wait_cyc(6);
      `CHK("rise without enable", 1'b0, cell_irq_flag)
      apply(4'h0);
      wait_cyc(6);
      `CHK("fall flag", 1'b1, cell_irq_flag)
      chk_rd("flag register", lcc_pkg::OFS_FLAG, 32'h00000001);
      wr(lcc_pkg::OFS_FLAG, 8'h01);
      wr(lcc_pkg::OFS_CTRL, 8'h92);
      wr(lcc_pkg::OFS_POL, 8'h8E);
      wait_cyc(6);
      `CHK("inverted output", 1'b1, cell_output_signal)
      `CHK("polarity edge flag", 1'b1, cell_irq_flag)
      // A clear landing on the edge that sets the flag must lose
      wr(lcc_pkg::OFS_FLAG, 8'h01);
      apply(4'h1);
      wait_cyc(6);
      `CHK("no flag before race", 1'b0, cell_irq_flag)
      apply(4'h0);
      wr(lcc_pkg::OFS_FLAG, 8'h01);
      `CHK("set beats clear", 1'b1, cell_irq_flag)
      $display("test edge flag done");
      // Reset in mid-run keeps gate polarity and selects
      @(posedge pclk);
      presetn <= 1'b0;
      wait_cyc(3);
      `CHK("output in reset", 1'b0, cell_output_signal)
      `CHK("flag in reset", 1'b0, cell_irq_flag)
      @(posedge pclk);
      presetn <= 1'b1;
      chk_rd("control after reset", lcc_pkg::OFS_CTRL, 32'h00000000);
      chk_rd("polarity kept", lcc_pkg::OFS_POL, 32'h0000000E);
      chk_rd("select kept", sel_ofs[0], 32'h00000027);
      $display("test reset done");
      give_verdict();
   end
endmodule // configurable_logic_cell_control_test
